// ===== rtl/cal_core_arith_logic_unit.sv
// arithmetic and logic unit of an 8-bit core with bit-accessible io registers
// assumes an APB master on clk and peripheral flag pulses on the same clock
`timescale 1ns/1ps
module cal_core_arith_logic_unit #(
    parameter cal_pkg::cal_io_bank_type IO_W1C_MASK = {{(cal_pkg::IO_COUNT-1){8'h00}}, 8'hF0}
) (
    // clock and synchronous reset
    input  wire logic                     clk,
    input  wire logic                     rst_b,
    // apb slave
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [7:0]               paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    // io register bank towards peripherals
    input  wire cal_pkg::cal_io_bank_type ioFlagSet,
    output cal_pkg::cal_io_bank_type      ioValue
);
    import cal_pkg::*;

    typedef enum {ST_IDLE, ST_EXEC} cal_state_type;

    cal_state_type   stateQ, stateD;
    cal_cmd_type     cmdQ, cmdD;
    cal_flags_type   flagsQ, flagsD;
    cal_io_bank_type ioQ, ioD;
    logic [15:0]     opaQ, opaD, resQ, resD;
    logic [7:0]      opbQ, opbD;
    logic [8:0]      wordLoQ, wordLoD;
    logic [1:0]      cntQ, cntD;
    logic            skipQ, skipD, ackQ, ackD, errQ, errD;
    logic [31:0]     rdataQ, rdataD;

    // flags of an 8-bit add or subtract
    function automatic cal_flags_type arithFlags(input logic [7:0] a, input logic [7:0] b,
                                                  input logic [7:0] r, input logic sub);
        cal_flags_type f;
        if (sub) begin
            f.h = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
            f.c = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
            f.v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
        end else begin
            f.h = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
            f.c = (a[7] & b[7]) | (b[7] & ~r[7]) | (~r[7] & a[7]);
            f.v = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
        end
        f.n = r[7];
        f.z = (r == 8'h00);
        f.s = f.n ^ f.v;
        return f;
    endfunction : arithFlags

    // zero, negative, overflow and sign for logic-style results, other flags kept
    function automatic cal_flags_type znvFlags(input cal_flags_type fin, input logic [7:0] r,
                                                input logic v);
        cal_flags_type f;
        f   = fin;
        f.n = r[7];
        f.z = (r == 8'h00);
        f.v = v;
        f.s = f.n ^ v;
        return f;
    endfunction : znvFlags

    // apb decode, read mux and error answer; a transfer is answered one cycle into access
    logic        access, ioHit, busy, cmdWr;
    logic [4:0]  ioIdx;
    always_comb begin
        access = psel & penable;
        ioHit  = paddr[7] & (paddr[1:0] == 2'h0);
        ioIdx  = paddr[6:2];
        busy   = (stateQ == ST_EXEC);
        cmdWr  = access & ackQ & pwrite & (paddr == OFS_CMD) & ~busy & ~errQ; // refused: no start
        ackD   = access & ~ackQ;
        rdataD = rdataQ;
        errD   = errQ;
        if (access & ~ackQ) begin
            rdataD = 32'h0000_0000;
            errD   = 1'b0;
            if (ioHit) begin
                rdataD[7:0] = ioQ[ioIdx];
            end else begin
                case (paddr)
                    OFS_OPA:  rdataD[15:0] = opaQ;
                    OFS_OPB:  rdataD[7:0]  = opbQ;
                    OFS_CMD:  begin
                        rdataD[12:0] = cmdQ;
                        errD         = pwrite & busy; // command refused while executing
                    end
                    OFS_RES:  begin
                        rdataD[15:0] = resQ;
                        errD         = pwrite;
                    end
                    OFS_STAT: rdataD = {22'h000000, skipQ, busy, 2'h0, flagsQ};
                    default:  errD   = 1'b1;
                endcase
            end
        end
    end

    assign pready  = access & ackQ;
    assign pslverr = access & ackQ & errQ;
    assign prdata  = rdataQ;
    assign ioValue = ioQ;

    // sequencer and datapath
    logic [7:0] a, b, r, kVal;
    logic [8:0] lo9;
    logic [7:0] hi;
    logic [15:0] r16;
    logic       done, useCarry, bitNow;
    always_comb begin
        stateD  = stateQ;
        cmdD    = cmdQ;
        cntD    = cntQ;
        resD    = resQ;
        flagsD  = flagsQ;
        skipD   = skipQ;
        wordLoD = wordLoQ;
        opaD    = opaQ;
        opbD    = opbQ;
        ioD     = ioQ;
        a       = opaQ[7:0];
        b       = opbQ;
        r       = 8'h00;
        hi      = 8'h00;
        r16     = 16'h0000;
        lo9     = 9'h000;
        kVal    = 8'h00;
        useCarry = 1'b0;
        bitNow  = ioQ[cmdQ.ioAddr][cmdQ.bitSel];
        done    = busy & (cntQ == 2'h0);
        // software access to operands, flags and io bank
        if (access & ackQ & pwrite & ~errQ) begin
            if (ioHit) begin
                // flagged bits clear on a written one, plain bits store
                ioD[ioIdx] = (pwdata[7:0] & ~IO_W1C_MASK[ioIdx]) |
                             (ioQ[ioIdx] & IO_W1C_MASK[ioIdx] & ~pwdata[7:0]);
            end else if (paddr == OFS_OPA) begin
                opaD = pwdata[15:0];
            end else if (paddr == OFS_OPB) begin
                opbD = pwdata[7:0];
            end else if (paddr == OFS_STAT) begin
                flagsD = pwdata[5:0];
            end
        end
        // start of an operation
        if (cmdWr) begin
            cmdD   = pwdata[12:0];
            stateD = ST_EXEC;
            case (cal_op_type'(pwdata[4:0]))
                OP_ADD_IMM_WORD, OP_SUB_IMM_WORD: cntD = CYC_WORD - 2'h1;
                OP_IO_BIT_SET, OP_IO_BIT_CLEAR:   cntD = CYC_IO_BIT - 2'h1;
                OP_SKIP_IF_IO_BIT_SET,
                OP_SKIP_IF_IO_BIT_CLEAR:          cntD = CYC_SKIP - 2'h1;
                default:                          cntD = CYC_BYTE - 2'h1;
            endcase
        end
        // first cycle of a word operation works on the low byte
        if (busy & ~done) begin
            cntD = cntQ - 2'h1;
            if (cmdQ.op == OP_SUB_IMM_WORD) begin
                wordLoD = {1'b0, opaQ[7:0]} - {1'b0, opbQ};
            end else begin
                wordLoD = {1'b0, opaQ[7:0]} + {1'b0, opbQ};
            end
        end
        // last cycle: result, flags and io effects
        if (done) begin
            stateD = ST_IDLE;
            case (cmdQ.op)
                OP_ADD, OP_ADD_CARRY: begin
                    useCarry = (cmdQ.op == OP_ADD_CARRY) & flagsQ.c;
                    r        = a + b + {7'h00, useCarry};
                    flagsD   = arithFlags(a, b, r, 1'b0);
                    resD     = {8'h00, r};
                end
                OP_SUB, OP_SUB_CONST, OP_SUB_CARRY, OP_SUB_CARRY_CONST: begin
                    useCarry = ((cmdQ.op == OP_SUB_CARRY) | (cmdQ.op == OP_SUB_CARRY_CONST))
                               & flagsQ.c;
                    r        = a - b - {7'h00, useCarry};
                    flagsD   = arithFlags(a, b, r, 1'b1);
                    resD     = {8'h00, r};
                end
                OP_ADD_IMM_WORD, OP_SUB_IMM_WORD: begin
                    if (cmdQ.op == OP_SUB_IMM_WORD) begin
                        hi       = opaQ[15:8] - {7'h00, wordLoQ[8]};
                        r16      = {hi, wordLoQ[7:0]};
                        flagsD.v = opaQ[15] & ~r16[15];
                        flagsD.c = r16[15] & ~opaQ[15];
                    end else begin
                        hi       = opaQ[15:8] + {7'h00, wordLoQ[8]};
                        r16      = {hi, wordLoQ[7:0]};
                        flagsD.v = ~opaQ[15] & r16[15];
                        flagsD.c = ~r16[15] & opaQ[15];
                    end
                    flagsD.n = r16[15];
                    flagsD.z = (r16 == 16'h0000);
                    flagsD.s = r16[15] ^ flagsD.v;
                    resD     = r16;
                end
                OP_AND, OP_AND_CONST, OP_OR, OP_OR_CONST, OP_XOR_REGS,
                OP_SET_BITS_MASK, OP_CLEAR_BITS_MASK, OP_ZERO_MINUS_TEST: begin
                    case (cmdQ.op)
                        OP_AND, OP_AND_CONST:    r = a & b;
                        OP_OR, OP_OR_CONST:      r = a | b;
                        OP_XOR_REGS:             r = a ^ b;
                        OP_SET_BITS_MASK:        r = a | b;
                        OP_CLEAR_BITS_MASK:      r = a & (ALL_ONES - b);
                        default:                 r = a & a;
                    endcase
                    flagsD = znvFlags(flagsQ, r, 1'b0);
                    resD   = {8'h00, r};
                end
                OP_ONES_COMPLEMENT: begin
                    r        = ALL_ONES - a;
                    flagsD   = znvFlags(flagsQ, r, 1'b0);
                    flagsD.c = 1'b1;
                    resD     = {8'h00, r};
                end
                OP_TWOS_COMPLEMENT: begin
                    r        = 8'h00 - a;
                    flagsD   = znvFlags(flagsQ, r, r == SIGN_MIN);
                    flagsD.c = (r != 8'h00);
                    flagsD.h = r[3] | a[3];
                    resD     = {8'h00, r};
                end
                OP_INC: begin
                    r      = a + 8'h01;
                    flagsD = znvFlags(flagsQ, r, r == SIGN_MIN);
                    resD   = {8'h00, r};
                end
                OP_DEC: begin
                    r      = a - 8'h01;
                    flagsD = znvFlags(flagsQ, r, r == SIGN_MAX);
                    resD   = {8'h00, r};
                end
                OP_IO_BIT_SET: begin
                    // a flagged bit sees the one as a clear, others untouched
                    kVal = 8'h01 << cmdQ.bitSel;
                    if (IO_W1C_MASK[cmdQ.ioAddr][cmdQ.bitSel]) begin
                        ioD[cmdQ.ioAddr] = ioD[cmdQ.ioAddr] & ~kVal;
                    end else begin
                        ioD[cmdQ.ioAddr] = ioD[cmdQ.ioAddr] | kVal;
                    end
                end
                OP_IO_BIT_CLEAR: begin
                    // writing zero leaves a flagged bit alone
                    kVal = 8'h01 << cmdQ.bitSel;
                    if (!IO_W1C_MASK[cmdQ.ioAddr][cmdQ.bitSel]) begin
                        ioD[cmdQ.ioAddr] = ioD[cmdQ.ioAddr] & ~kVal;
                    end
                end
                OP_SKIP_IF_IO_BIT_SET:   skipD = bitNow;
                OP_SKIP_IF_IO_BIT_CLEAR: skipD = ~bitNow;
                default: ;
            endcase
        end
        // peripheral events win over any clear in the same cycle
        ioD = ioD | ioFlagSet;
    end

    // state registers
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stateQ  <= ST_IDLE;
            cmdQ    <= '0;
            cntQ    <= 2'h0;
            resQ    <= RST_OPERAND;
            flagsQ  <= RST_FLAGS;
            skipQ   <= 1'b0;
            wordLoQ <= 9'h000;
            opaQ    <= RST_OPERAND;
            opbQ    <= RST_IO;
            ioQ     <= {IO_COUNT{RST_IO}};
            ackQ    <= 1'b0;
            errQ    <= 1'b0;
            rdataQ  <= 32'h0000_0000;
        end else begin
            stateQ  <= stateD;
            cmdQ    <= cmdD;
            cntQ    <= cntD;
            resQ    <= resD;
            flagsQ  <= flagsD;
            skipQ   <= skipD;
            wordLoQ <= wordLoD;
            opaQ    <= opaD;
            opbQ    <= opbD;
            ioQ     <= ioD;
            ackQ    <= ackD;
            errQ    <= errD;
            rdataQ  <= rdataD;
        end
    end
endmodule : cal_core_arith_logic_unit

// ===== rtl/cal_pkg.sv
// constants, types and the register map of the arithmetic and logic unit
// assumes one 10 MHz core clock and an APB master with 32-bit data
package cal_pkg;
    localparam int          IO_COUNT     = 32;       // bit-accessible io space 0x00..0x1F
    // byte offsets on the register bus
    localparam logic [7:0]  OFS_OPA      = 8'h00;    // destination, [15:0] pair for words
    localparam logic [7:0]  OFS_OPB      = 8'h04;    // source register or constant
    localparam logic [7:0]  OFS_CMD      = 8'h08;    // write starts an operation
    localparam logic [7:0]  OFS_RES      = 8'h0C;    // result, read only
    localparam logic [7:0]  OFS_STAT     = 8'h10;    // flags, busy, skip
    localparam logic [7:0]  OFS_IO_BASE  = 8'h80;    // io register n at 0x80 + 4n
    // status field positions
    localparam int          STAT_BUSY    = 8;
    localparam int          STAT_SKIP    = 9;
    // execution lengths in cycles
    localparam logic [1:0]  CYC_BYTE     = 2'h1;
    localparam logic [1:0]  CYC_WORD     = 2'h2;
    localparam logic [1:0]  CYC_IO_BIT   = 2'h2;
    localparam logic [1:0]  CYC_SKIP     = 2'h1;
    // values after reset, then the all-ones and sign limit constants of a byte
    localparam logic [15:0] RST_OPERAND  = 16'h0000;
    localparam logic [5:0]  RST_FLAGS    = 6'h00;
    localparam logic [7:0]  RST_IO       = 8'h00;
    localparam logic [7:0]  ALL_ONES     = 8'hFF;
    localparam logic [7:0]  SIGN_MIN     = 8'h80;
    localparam logic [7:0]  SIGN_MAX     = 8'h7F;

    typedef enum logic [4:0] {
        OP_ADD, OP_ADD_CARRY, OP_ADD_IMM_WORD, OP_SUB, OP_SUB_CONST, OP_SUB_CARRY,
        OP_SUB_CARRY_CONST, OP_SUB_IMM_WORD, OP_AND, OP_AND_CONST, OP_OR, OP_OR_CONST,
        OP_XOR_REGS, OP_ONES_COMPLEMENT, OP_TWOS_COMPLEMENT, OP_SET_BITS_MASK,
        OP_CLEAR_BITS_MASK, OP_INC, OP_DEC, OP_ZERO_MINUS_TEST, OP_IO_BIT_SET,
        OP_IO_BIT_CLEAR, OP_SKIP_IF_IO_BIT_SET, OP_SKIP_IF_IO_BIT_CLEAR
    } cal_op_type;

    // status flags, bit 0 carry up to bit 5 half carry
    typedef struct packed {
        logic h;
        logic s;
        logic v;
        logic n;
        logic z;
        logic c;
    } cal_flags_type;

    // command word: op [4:0], io address [9:5], bit index [12:10]
    typedef struct packed {
        logic [2:0] bitSel;
        logic [4:0] ioAddr;
        cal_op_type op;
    } cal_cmd_type;

    typedef logic [IO_COUNT-1:0][7:0] cal_io_bank_type;
endpackage : cal_pkg

// ===== sim/cal_core_arith_logic_unit_props.sv
// assertions on the bus answer and io bank of the arithmetic and logic unit
// assumes it is bound to cal_core_arith_logic_unit on its single clock
`timescale 1ns/1ps
module cal_core_arith_logic_unit_props (
    // clock and reset
    input wire logic                     clk,
    input wire logic                     rst_b,
    // apb
    input wire logic                     psel,
    input wire logic                     penable,
    input wire logic                     pwrite,
    input wire logic [7:0]               paddr,
    input wire logic [31:0]              pwdata,
    input wire logic [31:0]              prdata,
    input wire logic                     pready,
    input wire logic                     pslverr,
    // io bank
    input wire cal_pkg::cal_io_bank_type ioFlagSet,
    input wire cal_pkg::cal_io_bank_type ioValue
);
    import cal_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // answer timing on the bus
    AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
        else $error("pready outside an access phase");
    AST_ONE_WAIT: assert property ($rose(penable) && psel |-> !pready ##1 pready)
        else $error("access phase not exactly one wait state");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_PRDATA_HOLD: assert property (!(psel && penable) |=> $stable(prdata))
        else $error("read data moved while idle");
    // refused accesses
    AST_RES_READ_ONLY: assert property (pready && pwrite && paddr == OFS_RES |-> pslverr)
        else $error("write to result register accepted");
    AST_UNMAPPED: assert property (pready && paddr >= 8'h14 && paddr < OFS_IO_BASE |-> pslverr)
        else $error("unmapped access accepted");
    AST_IO_ALIGN: assert property (pready && paddr >= OFS_IO_BASE && paddr[1:0] != 2'h0
        |-> pslverr)
        else $error("unaligned io access accepted");
    // io bank after reset and on peripheral pulses
    AST_RESET_CLEAR: assert property ($rose(rst_b) |-> ioValue == '0 && prdata == 32'h0)
        else $error("bank or read data not cleared by reset");
    AST_FLAG_SET_WINS: assert property (ioFlagSet != '0
        |=> (ioValue & $past(ioFlagSet)) == $past(ioFlagSet))
        else $error("peripheral flag pulse lost");
    // main scenarios
    COV_ERR: cover property (pready && pslverr);
    COV_CMD: cover property (pready && pwrite && paddr == OFS_CMD);
    COV_FLAG: cover property (ioFlagSet != '0);
endmodule : cal_core_arith_logic_unit_props

bind cal_core_arith_logic_unit cal_core_arith_logic_unit_props u_props (
    .clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .ioFlagSet, .ioValue
);

// ===== sim/cal_core_arith_logic_unit_tb_top.sv
// self-checking bench for the arithmetic and logic unit over apb
// assumes the unit answers with one wait state and uses the mask set here
`timescale 1ns/1ps
module cal_core_arith_logic_unit_tb_top;
    import cal_pkg::*;
    typedef struct {
        logic [31:0]     mask;
        logic [31:0]     data;
        logic            err;
        cal_io_bank_type io;
    } cal_exp_type;
    localparam cal_io_bank_type W1C = {{31{8'h00}}, 8'hF0};
    // registers read back right after reset, all expected zero
    localparam logic [7:0] RST_RD [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h80, 8'hFC};
    logic            clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]      paddr = 8'h00;
    logic [31:0]     pwdata = 32'h0, prdata, seed = 32'hDC1E01B6;
    logic            pready, pslverr, skipM = 1'b0;
    cal_io_bank_type ioFlagSet = '0, ioValue, ioM = '0;
    cal_flags_type   flM = '0;
    logic [15:0]     resM = 16'h0;
    cal_exp_type     expQ[$], e;
    int              mismatches = 0, tests_run = 0;

    cal_core_arith_logic_unit #(.IO_W1C_MASK(W1C)) uut (.clk, .rst_b, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ioFlagSet, .ioValue);

    // 10 MHz clock
    always #50 clk = ~clk;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic check(input logic [255:0] got, input logic [255:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // one compare per kind of result: read data, error answer, io bank
    task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
        check(256'(got), 256'(exp));
    endtask : check_data

    task automatic check_err(input logic got, input logic exp);
        check(256'(got), 256'(exp));
    endtask : check_err

    task automatic check_io(input cal_io_bank_type got, input cal_io_bank_type exp);
        check(got, exp);
    endtask : check_io

    task automatic report_and_stop();
        if (mismatches == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop

    // one apb transfer; keep leaves psel up for a following setup
    task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] wd,
                       input logic [31:0] m, input logic [31:0] d, input logic err, input bit keep);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        expQ.push_back('{m, d, err, ioM});
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            mismatches++;
            report_and_stop();
        end
        if (!keep) begin
            psel    <= 1'b0;
            penable <= 1'b0;
            @(posedge clk);
        end
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err);
        apb(a, 1'b1, d, 32'h0, 32'h0, err, 1'b0);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] d);
        apb(a, 1'b0, 32'h0, m, d, 1'b0, 1'b0);
    endtask : rdc

    // expected result and flags of one command
    task automatic model(input logic [4:0] op, input logic [15:0] a, input logic [7:0] b);
        logic [16:0]   w;
        logic [8:0]    r;
        logic [4:0]    hh;
        logic          ci;
        int            k;
        cal_flags_type f;
        f  = flM;
        ci = (op == 5'd1 || op == 5'd5 || op == 5'd6) ? flM.c : 1'b0;
        r  = 9'h0;
        w  = 17'h0;
        k  = 1;
        case (cal_op_type'(op))
            OP_ADD, OP_ADD_CARRY: begin
                r   = a[7:0] + b + ci;
                hh  = a[3:0] + b[3:0] + ci;
                f.v = ~(a[7] ^ b[7]) & (a[7] ^ r[7]);
                f.c = r[8];
                f.h = hh[4];
            end
            OP_SUB, OP_SUB_CONST, OP_SUB_CARRY, OP_SUB_CARRY_CONST: begin
                r   = {1'b0, a[7:0]} - b - ci;
                hh  = {1'b0, a[3:0]} - b[3:0] - ci;
                f.v = (a[7] ^ b[7]) & (a[7] ^ r[7]);
                f.c = r[8];
                f.h = hh[4];
            end
            OP_AND, OP_AND_CONST: r = {1'b0, a[7:0] & b};
            OP_OR, OP_OR_CONST, OP_SET_BITS_MASK: r = {1'b0, a[7:0] | b};
            OP_XOR_REGS: r = {1'b0, a[7:0] ^ b};
            OP_CLEAR_BITS_MASK: r = {1'b0, a[7:0] & ~b};
            OP_ZERO_MINUS_TEST: r = {1'b0, a[7:0]};
            OP_ONES_COMPLEMENT: begin
                r   = {1'b0, ~a[7:0]};
                f.c = 1'b1;
            end
            OP_TWOS_COMPLEMENT: begin
                r   = {1'b0, 8'h00 - a[7:0]};
                f.c = r[7:0] != 8'h00;
                f.v = r[7:0] == 8'h80;
                f.h = r[3] | a[3];
            end
            OP_INC, OP_DEC: begin
                r   = (op == 5'd17) ? a[7:0] + 8'h01 : a[7:0] - 8'h01;
                f.v = (op == 5'd17) ? r[7:0] == 8'h80 : r[7:0] == 8'h7F;
            end
            OP_ADD_IMM_WORD, OP_SUB_IMM_WORD: begin
                w   = (op == 5'd2) ? a + b : {1'b0, a} - b;
                f.v = (op == 5'd2) ? ~a[15] & w[15] : a[15] & ~w[15];
                f.c = w[16];
                k   = 2;
            end
            default: k = 0;
        endcase
        if (op >= 5'h08 && op <= 5'h0D || op == 5'h0F || op == 5'h10 || op == 5'h13) f.v = 1'b0;
        if (k != 0) begin
            f.z  = (k == 2) ? w[15:0] == 16'h0 : r[7:0] == 8'h00;
            f.n  = (k == 2) ? w[15] : r[7];
            f.s  = f.n ^ f.v;
            flM  = f;
            resM = (k == 2) ? w[15:0] : {8'h00, r[7:0]};
        end
    endtask : model

    // compare every completed transfer with the oldest note
    always @(posedge clk) begin
        if (psel && penable && pready) begin
            e = expQ.pop_front();
            check_data(prdata & e.mask, e.data & e.mask);
            check_err(pslverr, e.err);
            check_io(ioValue, e.io);
        end
    end

    // watchdog
    initial begin
        repeat (30000) @(posedge clk);
        mismatches++;
        report_and_stop();
    end

    // main sequence
    initial begin
        logic [15:0]     a;
        logic [7:0]      b;
        logic [5:0]      fl;
        logic [31:0]     d;
        logic            long;
        cal_cmd_type     cmd;
        cal_io_bank_type fs;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        foreach (RST_RD[i]) begin
            rdc(RST_RD[i], 32'hFFFFFFFF, 32'h0);
        end
        apb(8'h14, 1'b0, 32'h0, 32'h0, 32'h0, 1'b1, 1'b0);
        wr(OFS_RES, rnd(), 1'b1);
        wr(8'h81, rnd(), 1'b1);
        for (int op = 0; op < 32; op++) begin
            for (int it = 0; it < 3; it++) begin
                a  = (it == 0) ? 16'hFF80 : (it == 1) ? 16'h007F : 16'(rnd());
                b  = (it == 0) ? 8'h80 : (it == 1) ? 8'h7F : 8'(rnd());
                fl = 6'(rnd());
                cmd.op     = cal_op_type'(op);
                cmd.ioAddr = 5'(rnd());
                cmd.bitSel = 3'(rnd());
                wr(OFS_OPA, {16'(rnd()), a}, 1'b0);
                wr(OFS_OPB, {24'(rnd()), b}, 1'b0);
                wr(OFS_STAT, {26'(rnd()), fl}, 1'b0);
                flM = fl;
                if (it == 2) begin
                    fs = '0;
                    fs[0] = 8'(rnd());
                    fs[cmd.ioAddr] = 8'(rnd());
                    ioFlagSet <= fs;
                    @(posedge clk);
                    ioFlagSet <= '0;
                    ioM = ioM | fs;
                end
                d = rnd();
                wr(OFS_IO_BASE + 8'({cmd.ioAddr, 2'b00}), d, 1'b0);
                ioM[cmd.ioAddr] = (ioM[cmd.ioAddr] & W1C[cmd.ioAddr] & ~d[7:0])
                                | (d[7:0] & ~W1C[cmd.ioAddr]);
                long = op == 2 || op == 7 || op == 20 || op == 21;
                apb(OFS_CMD, 1'b1, 32'(cmd), 32'h0, 32'h0, 1'b0, 1'b1);
                model(5'(op), a, b);
                if (op == 20) ioM[cmd.ioAddr][cmd.bitSel] = !W1C[cmd.ioAddr][cmd.bitSel];
                if (op == 21 && !W1C[cmd.ioAddr][cmd.bitSel]) ioM[cmd.ioAddr][cmd.bitSel] = 1'b0;
                if (op == 22) skipM = ioM[cmd.ioAddr][cmd.bitSel];
                if (op == 23) skipM = !ioM[cmd.ioAddr][cmd.bitSel];
                rdc(OFS_STAT, long ? 32'h300 : 32'h33F, {22'h0, skipM, long, 2'b00, flM});
                rdc(OFS_RES, 32'hFFFFFFFF, {16'h0, resM});
                rdc(OFS_STAT, 32'hFFFFFFFF, {22'h0, skipM, 3'b000, flM});
                rdc(OFS_IO_BASE + 8'({cmd.ioAddr, 2'b00}), 32'hFF, {24'h0, ioM[cmd.ioAddr]});
            end
        end
        apb(OFS_CMD, 1'b1, 32'(OP_ADD_IMM_WORD), 32'h0, 32'h0, 1'b0, 1'b1);
        model(5'd2, a, b);
        apb(OFS_CMD, 1'b1, 32'(OP_ADD), 32'h0, 32'h0, 1'b1, 1'b1);
        rdc(OFS_RES, 32'hFFFFFFFF, {16'h0, resM});
        report_and_stop();
    end
endmodule : cal_core_arith_logic_unit_tb_top
